// file: core/ehcp_port.sv
// host command and notification port of the embedded controller
// assumes host strobes are one-cycle pulses synchronous to i_ref_clk
`timescale 1ns/100ps
`include "ehcp_map.svh"
module ehcp_port #(
   parameter int unsigned AW    = `EHCP_ADDR_W,
   parameter int unsigned QD    = `EHCP_QDEPTH,
   parameter int unsigned PULSE = `EHCP_IRQ_CYC,
   parameter logic [7:0]  SMB   = `EHCP_SMB_CODE
) (
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_host_wr,
   input  wire logic                i_host_cmd_port,
   input  wire logic                i_host_env,
   input  wire logic [7:0]          i_host_wdata,
   input  wire logic                i_host_rd,
   input  wire ehcp_pkg::ehcp_evt_t i_os_evt,
   input  wire ehcp_pkg::ehcp_evt_t i_mgmt_evt,
   input  wire logic                i_smb_evt,
   output ehcp_pkg::ehcp_status_t   o_status,
   output logic [7:0]               o_rdata,
   output logic                     o_os_irq,
   output logic                     o_mgmt_irq,
   output logic [1:0]               o_evt_ready
);
   import ehcp_pkg::*;

   localparam int IBF_LIM = `EHCP_IBF_MAX_CYC;
   localparam int CNTW    = $clog2(PULSE + 1);

   logic              ibf_r;
   logic              obf_r;
   logic              cmd_r;
   logic              burst_r;
   logic              burst_nxt;
   logic              benv_r;
   logic              env_r;
   logic              env_nxt;
   logic [7:0]        ibuf_r;
   logic [AW-1:0]     waddr_r;
   logic [7:0]        mem_r [2**AW];
   ehcp_state_t       st_r;
   ehcp_state_t       st_nxt;
   ehcp_op_t          op;
   logic              ibf_irq;
   logic              irq_env;
   logic              ld;
   logic              ld_env;
   logic [7:0]        ld_val;
   logic              wr_mem;
   logic              smb_pend_r;
   logic [1:0]        push;
   logic [1:0]        pop;
   logic [1:0]        q_empty;
   logic [1:0]        q_ready;
   logic [1:0]        flag_q_r;
   logic [1:0]        trig;
   logic [1:0]        irq_r;
   logic [7:0]        q_din  [2];
   logic [7:0]        q_dout [2];
   logic [CNTW-1:0]   pcnt_r [2];
   ehcp_evt_t         evt    [2];

   // command byte decode [RULE_23]
   function automatic ehcp_op_t cmd_op(input logic [7:0] b);
      case (b)
         `EHCP_CMD_READ:     cmd_op = OP_READ;
         `EHCP_CMD_WRITE:    cmd_op = OP_WRITE;
         `EHCP_CMD_BURST_ON: cmd_op = OP_BURST_ON;
         `EHCP_CMD_BURST_OF: cmd_op = OP_BURST_OF;
         `EHCP_CMD_QUERY:    cmd_op = OP_QUERY;
         `EHCP_CMD_MQUERY:   cmd_op = OP_MQUERY;
         default:            cmd_op = OP_NONE;
      endcase
   endfunction : cmd_op

   assign op = cmd_op(ibuf_r);

   // host writes: latch byte, raise input full next edge [RULE_21]
   // a new byte wins over the consume of the old one
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ibf_r  <= 1'b0;
         cmd_r  <= 1'b0;
         benv_r <= `EHCP_ENV_OS;
         ibuf_r <= '0;
      end else if (i_host_wr) begin
         ibf_r  <= 1'b1;                  // [RULE_24]
         cmd_r  <= i_host_cmd_port;       // [RULE_24]
         benv_r <= i_host_env;            // [RULE_06]
         ibuf_r <= i_host_wdata;
      end else if (ibf_r) begin
         ibf_r  <= 1'b0;                  // [RULE_22]
      end
   end

   // consume one input byte; every transaction opens with a command
   always_comb begin
      st_nxt    = st_r;
      env_nxt   = env_r;
      burst_nxt = burst_r;
      ibf_irq   = 1'b0;
      irq_env   = env_r;
      ld        = 1'b0;
      ld_env    = env_r;
      ld_val    = `EHCP_SPURIOUS;
      wr_mem    = 1'b0;
      pop       = 2'b00;
      if (ibf_r && cmd_r) begin           // [RULE_20]
         env_nxt = benv_r;
         irq_env = benv_r;
         ld_env  = benv_r;
         st_nxt  = ST_IDLE;
         case (op)
            OP_READ: begin
               st_nxt  = ST_RD_ADDR;
               ibf_irq = 1'b1;            // [RULE_14]
            end
            OP_WRITE: begin
               st_nxt  = ST_WR_ADDR;
               ibf_irq = 1'b1;            // [RULE_15]
            end
            OP_BURST_ON: begin
               burst_nxt = 1'b1;          // [RULE_25]
               ld        = 1'b1;          // [RULE_17]
               ld_val    = `EHCP_BURST_ACK;
            end
            OP_BURST_OF: begin
               burst_nxt = 1'b0;
               ibf_irq   = 1'b1;          // [RULE_18]
            end
            OP_QUERY: begin               // [RULE_16] [RULE_10]
               ld        = 1'b1;
               ld_env    = `EHCP_ENV_OS;
               pop[0]    = !q_empty[0];   // [RULE_28]
               if (!q_empty[0]) begin
                  ld_val = q_dout[0];     // [RULE_01]
               end
            end
            OP_MQUERY: begin              // [RULE_09]
               ld        = 1'b1;
               ld_env    = `EHCP_ENV_MGMT;
               pop[1]    = !q_empty[1];
               if (!q_empty[1]) begin
                  ld_val = q_dout[1];
               end
            end
            default: ;                    // unknown code is dropped
         endcase
      end else if (ibf_r) begin
         st_nxt = ST_IDLE;
         case (st_r)
            ST_RD_ADDR: begin             // no irq for the address
               ld     = 1'b1;             // [RULE_14]
               ld_val = mem_r[ibuf_r[AW-1:0]];
            end
            ST_WR_ADDR: begin
               st_nxt  = ST_WR_DATA;
               ibf_irq = 1'b1;            // [RULE_15]
            end
            ST_WR_DATA: begin
               ibf_irq = 1'b1;            // [RULE_15]
               wr_mem  = 1'b1;
            end
            default: ;                    // stray data byte ignored
         endcase
      end
   end

   // sequencer, owning environment and burst flag
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r    <= ST_IDLE;
         env_r   <= `EHCP_ENV_OS;
         burst_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         env_r   <= env_nxt;
         burst_r <= burst_nxt;
      end
   end

   // address byte of a write is held until its data byte arrives
   always_ff @(posedge i_ref_clk) begin
      if (ibf_r && !cmd_r && st_r == ST_WR_ADDR) begin
         waddr_r <= ibuf_r[AW-1:0];
      end
      if (wr_mem) begin
         mem_r[waddr_r] <= ibuf_r;
      end
   end

   // output buffer: load sets full, host read clears it [RULE_22]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         obf_r   <= 1'b0;
         o_rdata <= '0;
      end else if (ld) begin
         obf_r   <= 1'b1;
         o_rdata <= ld_val;
      end else if (i_host_rd) begin
         obf_r   <= 1'b0;                 // [RULE_26]
      end
   end

   // event sources; zero codes are refused so zero stays spurious
   assign evt[0] = i_os_evt;
   assign evt[1] = i_mgmt_evt;

   // smbus notices wait one slot if an os event takes the queue
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         smb_pend_r <= 1'b0;
      end else if (i_smb_evt) begin
         smb_pend_r <= 1'b1;              // [RULE_05]
      end else if (push[0] && !(evt[0].vld && evt[0].code != '0)) begin
         smb_pend_r <= 1'b0;
      end
   end

   // per-environment queue, flag and interrupt pulse
   genvar e;
   generate
      for (e = 0; e < 2; e++) begin : g_env
         logic real_evt;
         assign real_evt = evt[e].vld && evt[e].code != '0; // [RULE_03]
         if (e == 0) begin : g_os
            assign push[e]  = (real_evt || smb_pend_r) && q_ready[e];
            assign q_din[e] = real_evt ? evt[e].code : SMB;
         end else begin : g_mg
            assign push[e]  = real_evt && q_ready[e];
            assign q_din[e] = evt[e].code;
         end

         // queue keeps notices while commands run [RULE_07]
         ehcp_evq #(.W(8), .DEPTH(QD)) u_q (
            .i_ref_clk (i_ref_clk),
            .i_rst_n   (i_rst_n),
            .i_push    (push[e]),
            .i_din     (q_din[e]),
            .i_pop     (pop[e]),
            .o_dout    (q_dout[e]),
            .o_empty   (q_empty[e]),
            .o_ready   (q_ready[e])
         );

         // flag rises first, the pulse follows one edge later [RULE_02]
         assign trig[e] = (ibf_irq && irq_env == 1'(e))
                       || (ld && ld_env == 1'(e))
                       || (!q_empty[e] && !flag_q_r[e]); // [RULE_13]

         // retrigger inside a pulse stretches it rather than adding edges
         always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               flag_q_r[e] <= 1'b0;
               pcnt_r[e]   <= '0;
               irq_r[e]    <= 1'b0;
            end else begin
               flag_q_r[e] <= !q_empty[e];
               if (trig[e]) begin
                  pcnt_r[e] <= CNTW'(PULSE);  // [RULE_27]
               end else if (pcnt_r[e] != '0) begin
                  pcnt_r[e] <= pcnt_r[e] - CNTW'(1);
               end
               irq_r[e] <= trig[e] || pcnt_r[e] > CNTW'(1); // [RULE_11]
            end
         end
      end
   endgenerate

   assign o_os_irq    = irq_r[0];
   assign o_mgmt_irq  = irq_r[1];
   assign o_evt_ready = q_ready;
   // flags only follow a detected event in their own queue [RULE_08]
   assign o_status = '{burst: burst_r, mgmt_evt: !q_empty[1],
                       os_evt: !q_empty[0], cmd: cmd_r,
                       output_full_flag: obf_r, input_full_flag: ibf_r};

   // length of the current os pulse, for checking only
   logic [7:0] hi_cnt_r;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hi_cnt_r <= '0;
      end else begin
         hi_cnt_r <= o_os_irq ? hi_cnt_r + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   ibf_set_a: assert property ( // [RULE_21]
      i_host_wr |-> ##[1:IBF_LIM] ibf_r)
      else $error("input full not raised after host write");
   cmd_flag_a: assert property ( // [RULE_24]
      i_host_wr |=> cmd_r == $past(i_host_cmd_port)
                 && ibuf_r == $past(i_host_wdata))
      else $error("command flag or input byte wrong");
   obf_clr_a: assert property ( // [RULE_26]
      i_host_rd && !ld |=> !obf_r)
      else $error("output full not cleared by host read");
   obf_src_a: assert property ( // [RULE_10]
      $rose(obf_r) |-> $past(ibf_r))
      else $error("output loaded without a received byte");
   burst_ack_a: assert property ( // [RULE_25]
      ibf_r && cmd_r && op == OP_BURST_ON |=>
      burst_r && obf_r && o_rdata == `EHCP_BURST_ACK ##1 o_os_irq
      || benv_r)
      else $error("burst entry incomplete");
   empty_query_a: assert property ( // [RULE_28]
      ibf_r && cmd_r && op == OP_QUERY && q_empty[0] |=>
      o_rdata == `EHCP_SPURIOUS && obf_r)
      else $error("empty query did not answer zero");
   flag_irq_a: assert property ( // [RULE_02]
      $rose(o_status.os_evt) |=> o_os_irq)
      else $error("event flag not followed by pulse");
   flag_cause_a: assert property ( // [RULE_08]
      $rose(o_status.os_evt) |-> $past(push[0]))
      else $error("event flag set without an event");
   nz_code_a: assert property ( // [RULE_03]
      push[0] |-> q_din[0] != `EHCP_SPURIOUS)
      else $error("zero code queued as an event");
   rd_addr_a: assert property ( // [RULE_14]
      ibf_r && !cmd_r && st_r == ST_RD_ADDR |=> obf_r)
      else $error("read result not loaded");
   irq_len_a: assert property ( // [RULE_27]
      $fell(o_os_irq) |-> hi_cnt_r >= 8'(PULSE))
      else $error("interrupt pulse too short");

   query_c: cover property (
      ibf_r && cmd_r && op == OP_QUERY && !q_empty[0]);
   burst_c: cover property (ibf_r && cmd_r && op == OP_BURST_ON);
   write_c: cover property (wr_mem);
   mquery_c: cover property (ibf_r && cmd_r && op == OP_MQUERY);
endmodule : ehcp_port

// file: core/ehcp_map.svh
// constant map of the host command port: byte codes, timings, sizes
// assumes one 40 MHz clock; included by the port module and the bench
//
// Summary of operation
// RULE_01: query loads one byte naming the cause of the pending event
// RULE_02: set event flag first, then pulse interrupt, then await query
// RULE_03: zero is returned only for a spurious query; causes are nonzero
// RULE_04: host queries only after seeing interrupt with event flag set
// RULE_05: smbus completion, error and alarm use one notify code
// RULE_06: commands tracked per environment; events routed per environment
// RULE_07: pending notifications are queued while commands are serviced
// RULE_08: event flag set only when an event for that side was detected
// RULE_09: management side has own flag and own query, served apart
// RULE_10: notifications enter output buffer only after a query command
// RULE_11: os interrupt is a pulse on a dedicated output
// RULE_12: host treats the interrupt as an edge event
// RULE_13: pulse on input empty, output full and event flag set
// RULE_14: read: irq on command consumed, none on address, irq on result
// RULE_15: write: irq after consuming command, address and data bytes
// RULE_16: query: no irq on command, irq when value loaded
// RULE_17: burst enter: no irq on command, irq when acknowledge loaded
// RULE_18: burst exit: irq once the command byte is consumed
// RULE_19: host owns the port before any exchange
// RULE_20: each transaction opens with a command byte then data bytes
// RULE_21: input full set within one microsecond of a host write
// RULE_22: input full clears on consume; output full set on load
// RULE_23: codes read 80, write 81, burst on 82, off 83, query 84
// RULE_24: command port write latches byte, sets input full and cmd flag
// RULE_25: burst entry sets burst flag, loads 90, sets output full, irq
// RULE_26: host data read returns output register, clears output full
// RULE_27: interrupt pulse lasts a parameterised number of cycles
// RULE_28: events queued, one per query; empty queue answers zero
`ifndef EHCP_MAP_SVH
`define EHCP_MAP_SVH
`define EHCP_CMD_READ     8'h80
`define EHCP_CMD_WRITE    8'h81
`define EHCP_CMD_BURST_ON 8'h82
`define EHCP_CMD_BURST_OF 8'h83
`define EHCP_CMD_QUERY    8'h84
`define EHCP_CMD_MQUERY   8'h85
`define EHCP_BURST_ACK    8'h90
`define EHCP_SPURIOUS     8'h00
`define EHCP_SMB_CODE     8'h01
`define EHCP_ENV_OS       1'b0
`define EHCP_ENV_MGMT     1'b1
`define EHCP_CLK_NS       25
`define EHCP_IBF_MAX_NS   1000
`define EHCP_IBF_MAX_CYC  (`EHCP_IBF_MAX_NS / `EHCP_CLK_NS)
`define EHCP_IRQ_CYC      4
`define EHCP_QDEPTH       8
`define EHCP_ADDR_W       8
`endif

// file: core/ehcp_pkg.sv
// types shared by the host command port, its host model and its bench
// assumes ehcp_map.svh holds every numeric constant
package ehcp_pkg;
   // command sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RD_ADDR = 2'b01,
      ST_WR_ADDR = 2'b10,
      ST_WR_DATA = 2'b11
   } ehcp_state_t;

   // decoded command byte
   typedef enum logic [2:0] {
      OP_NONE     = 3'b000,
      OP_READ     = 3'b001,
      OP_WRITE    = 3'b010,
      OP_BURST_ON = 3'b011,
      OP_BURST_OF = 3'b100,
      OP_QUERY    = 3'b101,
      OP_MQUERY   = 3'b110
   } ehcp_op_t;

   // six status flags as the host sees them
   typedef struct packed {
      logic burst;
      logic mgmt_evt;
      logic os_evt;
      logic cmd;
      logic output_full_flag;
      logic input_full_flag;
   } ehcp_status_t;

   // event report from the controller core
   typedef struct packed {
      logic       vld;
      logic [7:0] code;
   } ehcp_evt_t;
endpackage : ehcp_pkg

// file: core/ehcp_evq.sv
// notification queue: one per environment, codes popped one per query
// assumes DEPTH is a power of two so the pointers wrap by themselves
`timescale 1ns/100ps
module ehcp_evq #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_push,
   input  wire logic [W-1:0] i_din,
   input  wire logic         i_pop,
   output logic      [W-1:0] o_dout,
   output logic              o_empty,
   output logic              o_ready
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_r [DEPTH];
   logic [PW-1:0] wptr_r;
   logic [PW-1:0] rptr_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          do_push;
   logic          do_pop;

   // a push into a full queue is dropped; o_ready warns the source
   assign do_push = i_push && o_ready;
   assign do_pop  = i_pop && !o_empty;
   assign o_dout  = mem_r[rptr_r];

   // occupancy count
   always_comb begin
      cnt_nxt = cnt_r;
      if (do_push && !do_pop) begin
         cnt_nxt = cnt_r + CW'(1);
      end else if (do_pop && !do_push) begin
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   // storage has no reset; o_dout shows slot rptr_r, which holds a queued code whenever the queue is not empty
   always_ff @(posedge i_ref_clk) begin
      if (do_push) begin
         mem_r[wptr_r] <= i_din;
      end
   end

   // pointers, count and flags
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wptr_r  <= '0;
         rptr_r  <= '0;
         cnt_r   <= '0;
         o_empty <= 1'b1;
         o_ready <= 1'b1;
      end else begin
         if (do_push) begin
            wptr_r <= wptr_r + PW'(1);
         end
         if (do_pop) begin
            rptr_r <= rptr_r + PW'(1);
         end
         cnt_r   <= cnt_nxt;
         o_empty <= (cnt_nxt == '0);
         o_ready <= (cnt_nxt != CW'(DEPTH));
      end
   end
endmodule : ehcp_evq

// file: dv/ehcp_host.sv
// host-side model: byte writes to either port and data-port reads
// assumes the bench calls put and get; one owner drives at a time
`timescale 1ns/100ps
module ehcp_host (
   input  wire logic                   i_ref_clk,
   input  wire ehcp_pkg::ehcp_status_t i_status,
   input  wire logic [7:0]             i_rdata,
   output logic                        o_wr,
   output logic                        o_cmd_port,
   output logic                        o_env,
   output logic [7:0]                  o_wdata,
   output logic                        o_rd
);
   import ehcp_pkg::*;
   logic saw_ibf;
   logic saw_cmd;
   logic saw_obf;

   // idle host: no strobes on the port
   initial begin
      o_wr       = 1'b0;
      o_cmd_port = 1'b0;
      o_env      = 1'b0;
      o_wdata    = 8'h00;
      o_rd       = 1'b0;
   end

   // one byte; env names the owner of the exchange
   task automatic put(input logic cp, input logic env,
                      input logic [7:0] b);
      int n;
      @(posedge i_ref_clk);
      #1;
      o_wr       = 1'b1;
      o_cmd_port = cp; // command byte opens an exchange
      o_env      = env;
      o_wdata    = b;
      @(posedge i_ref_clk);
      #1;
      o_wr    = 1'b0;
      o_wdata = ~b; // released bus must not echo the last byte
      // input full stands one cycle only, so look right after the take
      saw_ibf = i_status.input_full_flag;
      saw_cmd = i_status.cmd;
      @(posedge i_ref_clk);
      #1;
      n = 0;
      // next byte only once this one was consumed
      while (i_status.input_full_flag !== 1'b0 && n < 40) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      // gap lets each interrupt pulse end before the next cause
      repeat (8) @(posedge i_ref_clk);
      #1;
   endtask : put

   // data-port read; the byte is taken at the edge that takes the strobe
   task automatic get(output logic [7:0] b);
      @(posedge i_ref_clk);
      #1;
      o_rd = 1'b1;
      @(posedge i_ref_clk);
      b = i_rdata;
      #1;
      o_rd = 1'b0;
      @(posedge i_ref_clk);
      #1;
      saw_obf = i_status.output_full_flag;
   endtask : get
endmodule : ehcp_host

// file: dv/ehcp_port_bench.sv
// self-checking bench for the host command port
// assumes ehcp_host drives the host side; events are driven here
`timescale 1ns/100ps
`include "ehcp_map.svh"
module ehcp_port_bench;
   import ehcp_pkg::*;
   localparam int PW = 4;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } ehcp_row_t;
   localparam ehcp_row_t ROWS [3] = '{'{8'h00, 8'h5a, 8'h5a},
      '{8'hff, 8'ha5, 8'ha5}, '{8'h3c, 8'h00, 8'h00}};
   logic         ref_clk;
   logic         rst_n;
   logic         wr, cp, env, rd, smb;
   logic [7:0]   wdata, rdata, b;
   ehcp_evt_t    os_evt, mg_evt;
   ehcp_status_t status;
   logic         os_irq, mg_irq, os_q, mg_q;
   logic [1:0]   evt_ready;
   int           os_n = 0, mg_n = 0, n0, m0, cyc = 0;
   int           fails = 0, compares = 0;

   ehcp_port #(.PULSE(PW)) i_dut (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_host_wr(wr),
      .i_host_cmd_port(cp), .i_host_env(env), .i_host_wdata(wdata),
      .i_host_rd(rd), .i_os_evt(os_evt), .i_mgmt_evt(mg_evt),
      .i_smb_evt(smb), .o_status(status), .o_rdata(rdata),
      .o_os_irq(os_irq), .o_mgmt_irq(mg_irq), .o_evt_ready(evt_ready));
   ehcp_host i_host (
      .i_ref_clk(ref_clk), .i_status(status), .i_rdata(rdata),
      .o_wr(wr), .o_cmd_port(cp), .o_env(env), .o_wdata(wdata),
      .o_rd(rd));

   // 40 MHz clock
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;

   // interrupts counted as rising edges, sampled mid-cycle
   always @(negedge ref_clk) begin
      os_q <= os_irq;
      mg_q <= mg_irq;
      if (os_irq === 1'b1 && os_q !== 1'b1) os_n <= os_n + 1; // edge
      if (mg_irq === 1'b1 && mg_q !== 1'b1) mg_n <= mg_n + 1; // edge
   end

   // ceiling far above the ~400 cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   // outputs while in reset and at the first edge after it
   task automatic rchk;
      chk({2'h0, status}, 8'h00, "reset status");
      chk(rdata, 8'h00, "reset rdata");
      chk({6'h0, os_irq, mg_irq}, 8'h00, "reset irq");
      chk({6'h0, evt_ready}, 8'h03, "reset ready");
   endtask : rchk

   // one event; with o set, flag first, then a pulse of PW cycles
   task automatic evt(input logic e, input logic [7:0] c, input bit o);
      int i;
      @(posedge ref_clk);
      #1;
      if (e) mg_evt = '{1'b1, c};
      else os_evt = '{1'b1, c};
      @(posedge ref_clk);
      #1;
      os_evt.vld = 1'b0;
      mg_evt.vld = 1'b0;
      if (o) begin
         // the flag stands one cycle ahead of the pulse
         chk(8'(e ? status.mgmt_evt : status.os_evt), 8'h01, "flag"); // set
         chk(8'(e ? mg_irq : os_irq), 8'h00, "irq early"); // order
         for (i = 0; i < PW; i++) begin
            @(posedge ref_clk);
            #1;
            chk(8'(e ? mg_irq : os_irq), 8'h01, "irq high");
         end
         @(posedge ref_clk);
         #1;
         chk(8'(e ? mg_irq : os_irq), 8'h00, "irq end");
      end
   endtask : evt

   // query from either side; one byte back and one interrupt
   task automatic qry(input logic e, input logic [7:0] exp);
      n0 = os_n;
      m0 = mg_n;
      i_host.put(1'b1, e, e ? `EHCP_CMD_MQUERY : `EHCP_CMD_QUERY);
      chk(8'(status.output_full_flag), 8'h01, "query obf"); // loaded
      i_host.get(b);
      chk(b, exp, "query value"); // code
      chk(8'(e ? mg_n - m0 : os_n - n0), 8'h01, "query irq");
      chk(8'(e ? os_n - n0 : mg_n - m0), 8'h00, "other irq"); // split
   endtask : qry

   initial begin
      rst_n  = 1'b0;
      smb    = 1'b0;
      os_evt = '0;
      mg_evt = '0;
      repeat (4) @(posedge ref_clk);
      rchk();
      #1;
      rst_n = 1'b1;
      // memory write then read back through the port
      foreach (ROWS[i]) begin
         n0 = os_n;
         i_host.put(1'b1, 1'b0, `EHCP_CMD_WRITE);
         chk(8'(i_host.saw_cmd), 8'h01, "cmd flag"); // set
         chk(8'(i_host.saw_ibf), 8'h01, "ibf set"); // fast
         i_host.put(1'b0, 1'b0, ROWS[i].addr);
         chk(8'(i_host.saw_cmd), 8'h00, "data flag"); // clear
         i_host.put(1'b0, 1'b0, ROWS[i].data);
         chk(8'(os_n - n0), 8'h03, "write irqs");
         n0 = os_n;
         i_host.put(1'b1, 1'b0, `EHCP_CMD_READ);
         i_host.put(1'b0, 1'b0, ROWS[i].addr);
         chk(8'(status.output_full_flag), 8'h01, "read obf"); // set
         i_host.get(b);
         chk(b, ROWS[i].exp, "read data"); // value
         chk(8'(i_host.saw_obf), 8'h00, "obf clear");
         chk(8'(os_n - n0), 8'h02, "read irqs");
      end
      // empty queue answers the spurious code
      qry(1'b0, `EHCP_SPURIOUS); // zero
      // a zero code is no event: no flag, no pulse
      n0 = os_n;
      evt(1'b0, 8'h00, 1'b0);
      repeat (4) @(posedge ref_clk);
      #1;
      chk(8'(status.os_evt), 8'h00, "zero flag");
      chk(8'(os_n - n0), 8'h00, "zero irq"); // none
      // two events before a write: held until asked, oldest first
      evt(1'b0, 8'h3c, 1'b1); // ordered
      evt(1'b0, 8'hc3, 1'b0);
      i_host.put(1'b1, 1'b0, `EHCP_CMD_WRITE);
      i_host.put(1'b0, 1'b0, 8'h10);
      i_host.put(1'b0, 1'b0, 8'h77);
      chk(8'(status.output_full_flag), 8'h00, "early load"); // none
      chk(8'(status.os_evt), 8'h01, "flag held"); // kept
      qry(1'b0, 8'h3c); // oldest
      qry(1'b0, 8'hc3); // next
      qry(1'b0, `EHCP_SPURIOUS); // drained
      // smbus notice uses its one code; its own pulse ends first
      @(posedge ref_clk);
      #1;
      smb = 1'b1;
      @(posedge ref_clk);
      #1;
      smb = 1'b0;
      repeat (10) @(posedge ref_clk);
      qry(1'b0, `EHCP_SMB_CODE); // notify
      // management side: own flag, own query, own interrupt
      evt(1'b1, 8'h42, 1'b1); // own path
      qry(1'b1, 8'h42); // served apart
      // burst entry and exit
      n0 = os_n;
      i_host.put(1'b1, 1'b0, `EHCP_CMD_BURST_ON);
      chk(8'(status.burst), 8'h01, "burst on"); // flag
      chk(8'(status.output_full_flag), 8'h01, "ack obf"); // loaded
      i_host.get(b);
      chk(b, `EHCP_BURST_ACK, "ack byte"); // value
      chk(8'(os_n - n0), 8'h01, "burst irq");
      n0 = os_n;
      i_host.put(1'b1, 1'b0, `EHCP_CMD_BURST_OF);
      chk(8'(status.burst), 8'h00, "burst off"); // cleared
      chk(8'(os_n - n0), 8'h01, "exit irq"); // one
      // a full management queue refuses its ninth notice
      for (int k = 0; k < `EHCP_QDEPTH; k++) begin
         evt(1'b1, 8'h10 + 8'(k), 1'b0);
      end
      chk({6'h0, evt_ready}, 8'h01, "mgmt full");
      evt(1'b1, 8'hee, 1'b0);
      qry(1'b1, 8'h10); // oldest kept
      chk({6'h0, evt_ready}, 8'h03, "mgmt room");
      // reset in mid-run with an event pending empties the queue
      evt(1'b0, 8'h55, 1'b0);
      rst_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      rchk();
      #1;
      rst_n = 1'b1;
      @(posedge ref_clk);
      #1;
      rchk();
      qry(1'b0, `EHCP_SPURIOUS); // emptied
      finish_test();
   end
endmodule : ehcp_port_bench
